// ===== core/bay_timing_config_and_reset.sv
// Special configuration register, presence timing, solenoid drive, reset.
//
// Register access over APB was left to the implementer.
`timescale 1ns/1ps
`default_nettype none
module bay_timing_config_and_reset #(
  parameter int TICK_CYC = bay_cfg_pkg::TICK_CYC
) (
  input  wire logic        clk_in,
  input  wire logic        nrst_in,
  input  wire logic        reset_pin_n_in,
  input  wire logic [7:0]  paddr_in,
  input  wire logic        psel_in,
  input  wire logic        penable_in,
  input  wire logic        pwrite_in,
  input  wire logic [31:0] pwdata_in,
  output logic      [31:0] prdata_out,
  output logic             pready_out,
  output logic             pslverr_out,
  input  wire logic [1:0]  usb_presence_pin_n_in,
  input  wire logic        addr_select_low_in,
  input  wire logic        addr_select_high_in,
  output logic      [1:0]  solenoid_drive_out,
  output logic      [1:0]  power_enable_out,
  output logic      [1:0]  status_change_out,
  output logic      [1:0]  bus_addr_out,
  output logic      [7:0]  addr_pointer_out
);

  function automatic logic hit(input logic [7:0] a, input logic [7:0] o);
    hit = (a == o);
  endfunction

  logic [1:0]             por_cnt_r;
  logic                   rst_int_r;
  bay_cfg_pkg::spec_cfg_s spec_r;
  logic                   spec_done_r;
  logic [1:0]             lock_r;
  logic [1:0]             pwr_r;
  logic [1:0]             flag_r;

  // Power-on hold counts first; the pin then keeps reset up while low.
  wire        por_busy  = (por_cnt_r < 2'(bay_cfg_pkg::POR_CYCLES));
  wire        rst_nxt   = por_busy | ~reset_pin_n_in;

  always_ff @(posedge clk_in or negedge nrst_in)
  begin
    if (!nrst_in)
      por_cnt_r <= 2'h0;
    else if (por_busy)
      por_cnt_r <= por_cnt_r + 2'h1;
  end

  always_ff @(posedge clk_in or negedge nrst_in)
  begin
    if (!nrst_in)
      rst_int_r <= 1'b1;
    else
      rst_int_r <= rst_nxt;
  end

  // APB slave: one wait-free access cycle after setup.
  wire        setup     = psel_in & ~penable_in;
  wire        acc_wr    = psel_in & penable_in & pready_out & pwrite_in
                          & ~rst_int_r;
  wire        wr_spec   = acc_wr & hit(paddr_in, bay_cfg_pkg::SPEC_CFG_OFS);
  wire        first_spec = wr_spec & ~spec_done_r;
  wire [1:0]  wr_ctrl;
  assign wr_ctrl[0] = acc_wr & hit(paddr_in, bay_cfg_pkg::BAY_CTRL0_OFS);
  assign wr_ctrl[1] = acc_wr & hit(paddr_in, bay_cfg_pkg::BAY_CTRL1_OFS);
  wire        new_lock  = pwdata_in[bay_cfg_pkg::LOCK_BIT];
  wire        new_pwr   = pwdata_in[bay_cfg_pkg::PWR_BIT];

  wire [31:0] ctrl0_q   = {24'h0, lock_r[0], 6'h0, pwr_r[0]};
  wire [31:0] ctrl1_q   = {24'h0, lock_r[1], 6'h0, pwr_r[1]};
  wire [31:0] stat0_q   = {31'h0, flag_r[0]};
  wire [31:0] stat1_q   = {31'h0, flag_r[1]};
  wire [31:0] spec_q    = {24'h0, spec_r};

  wire        mapped    = hit(paddr_in, bay_cfg_pkg::BAY_CTRL0_OFS)
                        | hit(paddr_in, bay_cfg_pkg::BAY_STAT0_OFS)
                        | hit(paddr_in, bay_cfg_pkg::BAY_CTRL1_OFS)
                        | hit(paddr_in, bay_cfg_pkg::BAY_STAT1_OFS)
                        | hit(paddr_in, bay_cfg_pkg::CTRL_CFG_OFS)
                        | hit(paddr_in, bay_cfg_pkg::SPEC_CFG_OFS);

  wire [31:0] rd_mux    =
    hit(paddr_in, bay_cfg_pkg::BAY_CTRL0_OFS) ? ctrl0_q :
    hit(paddr_in, bay_cfg_pkg::BAY_STAT0_OFS) ? stat0_q :
    hit(paddr_in, bay_cfg_pkg::BAY_CTRL1_OFS) ? ctrl1_q :
    hit(paddr_in, bay_cfg_pkg::BAY_STAT1_OFS) ? stat1_q :
    hit(paddr_in, bay_cfg_pkg::CTRL_CFG_OFS)  ? bay_cfg_pkg::CTRL_CFG_RST :
    hit(paddr_in, bay_cfg_pkg::SPEC_CFG_OFS)  ? spec_q : 32'h0;

  always_ff @(posedge clk_in or negedge nrst_in)
  begin
    if (!nrst_in)
    begin
      pready_out  <= 1'b0;
      pslverr_out <= 1'b0;
      prdata_out  <= 32'h0;
    end
    else
    begin
      pready_out  <= setup;
      pslverr_out <= setup & ~mapped;
      prdata_out  <= (setup & ~pwrite_in) ? rd_mux : 32'h0;
    end
  end

  // Address selects are caught and the pointer zeroed while internal reset holds.
  always_ff @(posedge clk_in or negedge nrst_in)
  begin
    if (!nrst_in)
    begin
      bus_addr_out     <= 2'h0;
      addr_pointer_out <= bay_cfg_pkg::PTR_RST;
    end
    else if (rst_int_r)
    begin
      bus_addr_out     <= {addr_select_high_in, addr_select_low_in};
      addr_pointer_out <= bay_cfg_pkg::PTR_RST;
    end
    else if (setup)
      addr_pointer_out <= paddr_in;
  end

  // Write-once configuration; permission returns on every reset.
  always_ff @(posedge clk_in or negedge nrst_in)
  begin
    if (!nrst_in)
    begin
      spec_r      <= bay_cfg_pkg::spec_cfg_s'(bay_cfg_pkg::SPEC_CFG_RST[7:0]);
      spec_done_r <= 1'b0;
    end
    else if (rst_int_r)
    begin
      spec_r      <= bay_cfg_pkg::spec_cfg_s'(bay_cfg_pkg::SPEC_CFG_RST[7:0]);
      spec_done_r <= 1'b0;
    end
    else if (first_spec)
    begin
      spec_r      <= bay_cfg_pkg::spec_cfg_s'(pwdata_in[7:0]);
      spec_done_r <= 1'b1;
    end
  end

  // One debounce tick comes first, then sixteen ticks per time-out step.
  wire [2:0] tmo_step  = spec_r.insertion_timeout_field;
  wire [3:0] pulse_len = spec_r.solenoid_length_field;
  wire       long_sel  = spec_r.long_pulse_select;
  wire [7:0] ins_ticks = {1'b0, tmo_step, 4'h0} + 8'h01;
  wire [7:0] pul_ticks = long_sel ? {pulse_len, 4'h0}
                                  : {4'h0, pulse_len};
  wire       level     = (pulse_len == 4'h0);

  genvar i;
  generate
    for (i = 0; i < 2; i = i + 1)
    begin : g_bay
      logic        pres_r;
      logic [21:0] dcyc_r;
      logic [7:0]  dtick_r;
      logic [21:0] scyc_r;
      logic [7:0]  stick_r;
      logic        pulsing_r;
      wire  dwrap = (dcyc_r == 22'(TICK_CYC - 1));
      wire  swrap = (scyc_r == 22'(TICK_CYC - 1));
      wire  [7:0] dlim = pres_r ? ins_ticks : bay_cfg_pkg::DEB_TICKS;
      wire  ddone = dwrap & (dtick_r + 8'h01 == dlim);
      wire  fall  = wr_ctrl[i] & lock_r[i] & ~new_lock;
      wire  sdone = swrap & (stick_r + 8'h01 == pul_ticks);

      // Any bounce back to the reported state restarts the whole wait.
      always_ff @(posedge clk_in or negedge nrst_in)
      begin
        if (!nrst_in)
        begin
          pres_r  <= 1'b0;
          dcyc_r  <= 22'h0;
          dtick_r <= 8'h0;
          flag_r[i] <= 1'b0;
          status_change_out[i] <= 1'b0;
        end
        else if (rst_int_r)
        begin
          pres_r  <= 1'b0;
          dcyc_r  <= 22'h0;
          dtick_r <= 8'h0;
          flag_r[i] <= 1'b0;
          status_change_out[i] <= 1'b0;
        end
        else
        begin
          pres_r <= ~usb_presence_pin_n_in[i];
          status_change_out[i] <= 1'b0;
          if (pres_r == flag_r[i])
          begin
            dcyc_r  <= 22'h0;
            dtick_r <= 8'h0;
          end
          else if (ddone)
          begin
            flag_r[i] <= pres_r;
            status_change_out[i] <= pres_r;
            dcyc_r  <= 22'h0;
            dtick_r <= 8'h0;
          end
          else
          begin
            dcyc_r  <= dwrap ? 22'h0 : dcyc_r + 22'h1;
            dtick_r <= dwrap ? dtick_r + 8'h01 : dtick_r;
          end
        end
      end

      // Lock and power control bits of the bay control register.
      always_ff @(posedge clk_in or negedge nrst_in)
      begin
        if (!nrst_in)
        begin
          lock_r[i] <= 1'b0;
          pwr_r[i]  <= 1'b0;
          power_enable_out[i] <= 1'b0;
        end
        else if (rst_int_r)
        begin
          lock_r[i] <= 1'b0;
          pwr_r[i]  <= 1'b0;
          power_enable_out[i] <= 1'b0;
        end
        else
        begin
          if (first_spec)
            lock_r[i] <= 1'b0;
          else if (wr_ctrl[i])
            lock_r[i] <= new_lock;
          if (wr_ctrl[i])
            pwr_r[i] <= new_pwr;
          power_enable_out[i] <= pwr_r[i];
        end
      end

      // A new falling write during a pulse restarts the pulse width.
      always_ff @(posedge clk_in or negedge nrst_in)
      begin
        if (!nrst_in)
        begin
          scyc_r    <= 22'h0;
          stick_r   <= 8'h0;
          pulsing_r <= 1'b0;
          solenoid_drive_out[i] <= 1'b0;
        end
        else if (rst_int_r || first_spec)
        begin
          scyc_r    <= 22'h0;
          stick_r   <= 8'h0;
          pulsing_r <= 1'b0;
          solenoid_drive_out[i] <= 1'b0;
        end
        else if (level)
        begin
          pulsing_r <= 1'b0;
          solenoid_drive_out[i] <= lock_r[i];
        end
        else if (fall)
        begin
          scyc_r    <= 22'h0;
          stick_r   <= 8'h0;
          pulsing_r <= 1'b1;
          solenoid_drive_out[i] <= 1'b1;
        end
        else if (pulsing_r)
        begin
          scyc_r  <= swrap ? 22'h0 : scyc_r + 22'h1;
          stick_r <= swrap ? stick_r + 8'h01 : stick_r;
          if (sdone)
          begin
            pulsing_r <= 1'b0;
            solenoid_drive_out[i] <= 1'b0;
          end
        end
        else
          solenoid_drive_out[i] <= 1'b0;
      end

      level_follow_a: assert property (
        @(posedge clk_in) disable iff (!nrst_in)
        (!rst_int_r && level && !first_spec && $stable(spec_r))
        |=> (solenoid_drive_out[i] == $past(lock_r[i])))
        else $error("level mode solenoid does not follow lock bit");

      pulse_start_a: assert property (
        @(posedge clk_in) disable iff (!nrst_in)
        (!rst_int_r && !level && fall && !first_spec)
        |=> solenoid_drive_out[i] && pulsing_r)
        else $error("falling lock write did not start a pulse");

      pulse_end_a: assert property (
        @(posedge clk_in) disable iff (!nrst_in)
        (!rst_int_r && pulsing_r && sdone && !fall && !first_spec)
        |=> !solenoid_drive_out[i])
        else $error("pulse did not end at programmed width");

      flag_quiet_a: assert property (
        @(posedge clk_in) disable iff (!nrst_in)
        (!rst_int_r && !flag_r[i] && !ddone) |=> !flag_r[i])
        else $error("presence flag set before debounce and time-out");

      first_clear_a: assert property (
        @(posedge clk_in) disable iff (!nrst_in)
        (first_spec && !rst_int_r)
        |=> !lock_r[i] && !solenoid_drive_out[i])
        else $error("first config write did not clear lock state");
    end
  endgenerate

  spec_once_a: assert property (
    @(posedge clk_in) disable iff (!nrst_in)
    (spec_done_r && !rst_int_r) |=> $stable(spec_r))
    else $error("config changed after first write");

  spec_high_a: assert property (
    @(posedge clk_in) disable iff (!nrst_in)
    (pready_out && !pslverr_out && $past(hit(paddr_in,
      bay_cfg_pkg::SPEC_CFG_OFS)))
    |-> (prdata_out[31:8] == 24'h0))
    else $error("reserved config bits read nonzero");

  reset_clear_a: assert property (
    @(posedge clk_in) disable iff (!nrst_in)
    rst_int_r |=> (spec_r == 8'h00) && (flag_r == 2'h0)
      && (lock_r == 2'h0) && !spec_done_r)
    else $error("internal reset left state set");

  por_len_a: assert property (@(posedge clk_in)
    $rose(nrst_in) |-> rst_int_r ##1 rst_int_r)
    else $error("power-on reset shorter than two cycles");

  pin_reset_a: assert property (
    @(posedge clk_in) disable iff (!nrst_in)
    !reset_pin_n_in |=> rst_int_r)
    else $error("reset pin did not reset the block");

  ptr_reset_a: assert property (
    @(posedge clk_in) disable iff (!nrst_in)
    rst_int_r |=> (addr_pointer_out == bay_cfg_pkg::PTR_RST))
    else $error("pointer not cleared by reset");

endmodule
`default_nettype wire

// ===== dv/bay_partner.sv
// Model of the bay presence switches and the lock solenoid load.
`timescale 1ns/1ps
`default_nettype none
module bay_partner (
  input  wire logic [0:0]       clk_in,
  input  wire logic [1:0]       insert_in,
  input  wire logic [1:0]       solenoid_drive_in,
  output logic      [1:0]       usb_presence_pin_n_out,
  output logic      [1:0][15:0] pulse_len_out
);
  logic [1:0][15:0] run_r = '0;

  // The width output stays unknown until the first pulse has ended.
  // An empty bay's pin is pulled up, so it reads high.
  assign usb_presence_pin_n_out = ~insert_in;

  // The solenoid is timed in clock cycles and the width is kept on release.
  always @(posedge clk_in)
  begin
    for (int b = 0; b < 2; b++)
    begin
      if (solenoid_drive_in[b] === 1'b1)
        run_r[b] <= run_r[b] + 16'h0001;
      else if (run_r[b] != 16'h0000)
      begin
        pulse_len_out[b] <= run_r[b];
        run_r[b]         <= 16'h0000;
      end
    end
  end
endmodule
`default_nettype wire

// ===== dv/bay_timing_config_and_reset_tb.sv
// Self-checking bench for the bay timing and configuration block.
`timescale 1ns/1ps
`default_nettype none
module bay_timing_config_and_reset_tb;
  localparam int         TICK  = 10;
  localparam logic [7:0] SPEC  = bay_cfg_pkg::SPEC_CFG_OFS;
  localparam logic [7:0] CTL0  = bay_cfg_pkg::BAY_CTRL0_OFS;
  localparam logic [7:0] CTL1  = bay_cfg_pkg::BAY_CTRL1_OFS;
  localparam logic [7:0] STAT0 = bay_cfg_pkg::BAY_STAT0_OFS;
  logic             clk_in, nrst_in, pin_n, psel, pen, pwr, pready, pslverr;
  logic             err;
  logic [7:0]       paddr, ptr;
  logic [31:0]      pwdata, prdata, rd;
  logic [1:0]       ins, pres_n, drive, pwr_en, chg, bus_addr, sel;
  logic [1:0][15:0] plen;
  int               mismatches = 0;
  int               tests_run  = 0;
  int               cyc        = 0;

  bay_timing_config_and_reset #(.TICK_CYC(TICK)) dut (
    .clk_in(clk_in), .nrst_in(nrst_in), .reset_pin_n_in(pin_n),
    .paddr_in(paddr), .psel_in(psel), .penable_in(pen), .pwrite_in(pwr),
    .pwdata_in(pwdata), .prdata_out(prdata), .pready_out(pready),
    .pslverr_out(pslverr), .usb_presence_pin_n_in(pres_n),
    .addr_select_low_in(sel[0]), .addr_select_high_in(sel[1]),
    .solenoid_drive_out(drive), .power_enable_out(pwr_en),
    .status_change_out(chg), .bus_addr_out(bus_addr),
    .addr_pointer_out(ptr));

  bay_partner far (.clk_in(clk_in), .insert_in(ins),
    .solenoid_drive_in(drive), .usb_presence_pin_n_out(pres_n),
    .pulse_len_out(plen));

  initial
  begin
    clk_in = 1'b0;
    forever #10 clk_in = ~clk_in;
  end

  // The ceiling is well above the longest planned run of about 600 cycles.
  always @(posedge clk_in)
  begin
    cyc <= cyc + 1;
    if (cyc == 20000)
    begin
      mismatches = mismatches + 1;
      summarize();
    end
  end

  task automatic summarize();
    if (mismatches == 0 && tests_run > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask

  task automatic chk(input string nm, input logic [31:0] exp, got);
    tests_run++;
    if (got !== exp)
    begin
      mismatches++;
      $display("mismatch %s expected %h seen %h", nm, exp, got);
    end
  endtask

  task automatic apb(input logic w, input logic [7:0] a,
                     input logic [31:0] d);
    int n;
    n = 0;
    @(posedge clk_in);
    psel   <= 1'b1;
    pen    <= 1'b0;
    pwr    <= w;
    paddr  <= a;
    pwdata <= d;
    @(posedge clk_in);
    pen <= 1'b1;
    do
    begin
      @(posedge clk_in);
      n++;
    end
    while (pready !== 1'b1);
    rd  = prdata;
    err = pslverr;
    psel <= 1'b0;
    pen  <= 1'b0;
    chk("wait states", 32'h1, 32'(n));
  endtask

  task automatic rdchk(input string nm, input logic [7:0] a,
                       input logic [31:0] exp);
    apb(1'b0, a, 32'h0);
    chk(nm, exp, rd);
  endtask

  // The pin is held for exactly the shortest legal low time.
  task automatic pin_reset();
    @(posedge clk_in);
    pin_n <= 1'b0;
    repeat (6) @(posedge clk_in);
    pin_n <= 1'b1;
    repeat (4) @(posedge clk_in);
  endtask

  task automatic t_reset();
    chk("bus addr", 32'h2, 32'(bus_addr));
    chk("pointer", 32'h0, 32'(ptr));
    chk("outputs", 32'h0, 32'({drive, pwr_en, chg}));
    rdchk("spec", SPEC, 32'h0);
    rdchk("ctrl cfg", bay_cfg_pkg::CTRL_CFG_OFS, 32'h2);
    rdchk("ctrl0", CTL0, 32'h0);
    rdchk("stat1", bay_cfg_pkg::BAY_STAT1_OFS, 32'h0);
    apb(1'b1, 8'h40, 32'h1);
    chk("slverr", 32'h1, 32'(err));
  endtask

  task automatic t_level();
    apb(1'b1, CTL0, 32'h80);
    repeat (2) @(posedge clk_in);
    chk("level on", 32'h1, 32'(drive[0]));
    apb(1'b1, SPEC, 32'h01);
    rdchk("lock clr", CTL0, 32'h0);
    chk("drive clr", 32'h0, 32'(drive[0]));
    apb(1'b1, CTL0, 32'h80);
    repeat (2) @(posedge clk_in);
    chk("long sel idle", 32'h1, 32'(drive[0]));
    apb(1'b1, SPEC, 32'hffff_ffff);
    rdchk("spec once", SPEC, 32'h01);
    chk("no reclr", 32'h1, 32'(drive[0]));
    apb(1'b1, CTL0, 32'h00);
    repeat (2) @(posedge clk_in);
    chk("level off", 32'h0, 32'(drive[0]));
  endtask

  task automatic t_pulse(input logic [31:0] cfg, input int w);
    pin_reset();
    rdchk("spec rst", SPEC, 32'h0);
    apb(1'b1, SPEC, cfg);
    rdchk("spec rd", SPEC, 32'(cfg[7:0]));
    apb(1'b1, CTL1, 32'h80);
    apb(1'b1, CTL1, 32'h00);
    repeat (w * TICK + 20) @(posedge clk_in);
    chk("pulse", 32'(w * TICK), 32'(plen[1]));
  endtask

  // Debounce of one tick plus the time-out in long ticks of 16.
  task automatic t_presence(input int ito);
    int n;
    int d;
    n = 0;
    d = (1 + ito * 16) * TICK;
    @(posedge clk_in);
    ins[0] <= 1'b1;
    do
    begin
      @(posedge clk_in);
      n++;
    end
    while (chg[0] !== 1'b1 && n < 400);
    chk("ins delay", 32'h1, 32'(n >= d && n <= d + 5));
    @(posedge clk_in);
    chk("event", 32'h0, 32'(chg[0]));
    rdchk("present", STAT0, 32'h1);
    ins[0] <= 1'b0;
    repeat (TICK + 10) @(posedge clk_in);
    rdchk("absent", STAT0, 32'h0);
  endtask

  initial
  begin
    nrst_in = 1'b0;
    pin_n   = 1'b1;
    psel    = 1'b0;
    pen     = 1'b0;
    pwr     = 1'b0;
    paddr   = 8'h00;
    pwdata  = 32'h0;
    ins     = 2'b00;
    sel     = 2'b10;
    repeat (12) @(posedge clk_in);
    nrst_in <= 1'b1;
    repeat (4) @(posedge clk_in);
    t_reset();
    t_level();
    t_pulse(32'hffff_ff26, 3);
    t_presence(1);
    t_pulse(32'h0000_0003, 16);
    t_presence(0);
    summarize();
  end
endmodule
`default_nettype wire

// ===== inc/bay_cfg_pkg.sv
// Constants, register map and field layouts for the bay timing block.
// Function
// - USB present flag reads as the inverted USB presence pin.
// - Flag rise may raise a status change event; reset clears the flag.
// - Special config bits 31:8 always read zero; low byte is config.
// - Special config accepts only the first write after reset; resets to 0.
// - Insertion time-out is field value times 800 ms.
// - Insertion is reported only after the selected time-out.
// - Presence inputs are debounced 50 ms before the time-out begins.
// - Solenoid length zero gives level mode following the lock bit.
// - Nonzero length pulses solenoid on each lock bit 1 to 0 write.
// - Pulse width is length times 50 ms, or length times 800 ms if long select.
// - Long-pulse select has no effect in level mode.
// - First length write clears lock bits and solenoid outputs.
// - External reset pin and power-on reset are ORed together.
// - Power-on reset lasts two cycles, then waits for the pin high.
// - Reset clears control, status, config and all drive outputs.
// - Reset loads controller config with two bays, no locks.
// - Reset restores write permission of every write-once field.
// - Reset samples address selects and zeroes the register pointer.
package bay_cfg_pkg;

  localparam logic [7:0]  BAY_CTRL0_OFS = 8'h10;
  localparam logic [7:0]  BAY_STAT0_OFS = 8'h14;
  localparam logic [7:0]  BAY_CTRL1_OFS = 8'h1c;
  localparam logic [7:0]  BAY_STAT1_OFS = 8'h20;
  localparam logic [7:0]  CTRL_CFG_OFS  = 8'h24;
  localparam logic [7:0]  SPEC_CFG_OFS  = 8'hfc;

  localparam int          LOCK_BIT      = 7;
  localparam int          PWR_BIT       = 0;
  localparam int          PRESENT_BIT   = 0;

  localparam logic [31:0] SPEC_CFG_RST  = 32'h0000_0000;
  localparam logic [31:0] CTRL_CFG_RST  = 32'h0000_0002;
  localparam logic [7:0]  PTR_RST       = 8'h00;

  localparam int          POR_CYCLES    = 2;
  localparam longint      CLK_HZ        = 50000000;
  localparam longint      TICK_MS       = 50;
  localparam longint      LONG_MS       = 800;
  localparam int          TICK_CYC      = int'((TICK_MS * CLK_HZ) / 1000);
  localparam logic [7:0]  LONG_TICKS    = 8'(LONG_MS / TICK_MS);
  localparam logic [7:0]  DEB_TICKS     = 8'h01;

  typedef struct packed {
    logic [2:0] insertion_timeout_field;
    logic [3:0] solenoid_length_field;
    logic       long_pulse_select;
  } spec_cfg_s;

endpackage
